/* File: src/monitor_pkg.sv */
package monitor_pkg;
	// ==========================================
	// Register map
	// ==========================================
	localparam logic [7:0] CFG_ADDR = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h01;
	localparam logic [7:0] MASK_ADDR = 8'h03;
	localparam logic [7:0] RESULT_BASE = 8'h20;
	localparam logic [7:0] TEMP_RESULT_ADDR = 8'h27;
	localparam logic [7:0] LIMIT_BASE = 8'h2A;
	localparam logic [7:0] TEMP_HIGH_ADDR = 8'h38;
	localparam logic [7:0] TEMP_HYST_ADDR = 8'h39;
	localparam int RESULT_COUNT = 8;
	localparam int LIMIT_COUNT = 16;
	localparam logic [3:0] TEMP_HIGH_IDX = 4'(TEMP_HIGH_ADDR - LIMIT_BASE);
	localparam logic [3:0] TEMP_HYST_IDX = 4'(TEMP_HYST_ADDR - LIMIT_BASE);
	localparam logic [2:0] TEMP_CHAN = 3'(TEMP_RESULT_ADDR - RESULT_BASE);

	// ==========================================
	// Control fields and reset values
	// ==========================================
	localparam int CFG_START_BIT = 0;
	localparam int CFG_INT_EN_BIT = 1;
	localparam int CFG_INT_CLEAR_BIT = 3;
	localparam int CFG_INIT_BIT = 7;
	localparam logic [7:0] CFG_RESET = 8'h08;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] LIMIT_RESET = 8'h00;

	// ==========================================
	// Serial link
	// ==========================================
	// Base of the nine strap addresses; value is arbitrary
	localparam logic [6:0] BUS_ADDR_BASE = 7'h10;
	localparam logic [6:0] STRAP_STEP = 7'h03;
	localparam logic [3:0] BIT_COUNT = 4'h8;
	localparam logic [3:0] ACK_COUNT = 4'h9;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_PTR = 3'h3,
		ST_WDATA = 3'h2,
		ST_RDATA = 3'h5,
		ST_WAIT = 3'h4
	} link_state_e;

	typedef struct packed {
		logic [2:0] chan;
		logic [11:0] data;
	} conv_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic hi;
		logic [7:0] ptr;
		logic [7:0] wdata;
	} bus_req_s;
endpackage : monitor_pkg

/* File: src/result_mem.sv */
`timescale 1ns/100ps
module result_mem
	import monitor_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic we_i,
	input wire logic [2:0] waddr_i,
	input wire logic [15:0] wdata_i,
	input wire logic [2:0] raddr_i,
	output logic [15:0] rdata_o
);
	logic [15:0] mem_reg [RESULT_COUNT];

	always_ff @(posedge core_clk_i) begin
		if (we_i) begin
			mem_reg[waddr_i] <= wdata_i;
		end
		rdata_o <= mem_reg[raddr_i];
	end
endmodule : result_mem

/* File: src/serial_link_slave.sv */
`timescale 1ns/100ps
module serial_link_slave
	import monitor_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic [6:0] own_addr_i,
	input wire logic [7:0] rd_byte_i,
	output logic sda_oe_n_o,
	output logic busy_o,
	output bus_req_s req_o
);
	// ==========================================
	// Pin synchronisers and edges
	// ==========================================
	logic scl_s1_reg, scl_s2_reg, scl_d_reg;
	logic sda_s1_reg, sda_s2_reg, sda_d_reg;
	link_state_e state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] shin_reg, tx_reg, tx_next, ptr_reg, ptr_next;
	logic drv_reg, drv_next, hi_reg, hi_next;
	logic wr_pulse, rd_pulse;

	wire scl_rise = scl_s2_reg && !scl_d_reg;
	wire scl_fall = !scl_s2_reg && scl_d_reg;
	wire start_det = scl_s2_reg && scl_d_reg && sda_d_reg && !sda_s2_reg;
	wire stop_det = scl_s2_reg && scl_d_reg && !sda_d_reg && sda_s2_reg;
	wire addr_hit = shin_reg[7:1] == own_addr_i;
	wire in_read = state_reg == ST_RDATA;

	always_ff @(posedge core_clk_i) begin
		scl_s1_reg <= scl_i;
		sda_s1_reg <= sda_i;
	end

	// Idle high after reset, so no false start or edge
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			scl_s2_reg <= 1'b1;
			scl_d_reg <= 1'b1;
			sda_s2_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_s2_reg <= scl_s1_reg;
			scl_d_reg <= scl_s2_reg;
			sda_s2_reg <= sda_s1_reg;
			sda_d_reg <= sda_s2_reg;
		end
	end

	// ==========================================
	// Byte engine
	// ==========================================
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		drv_next = drv_reg;
		tx_next = tx_reg;
		ptr_next = ptr_reg;
		hi_next = hi_reg;
		wr_pulse = 1'b0;
		rd_pulse = 1'b0;
		if (start_det) begin
			state_next = ST_ADDR;
			cnt_next = 4'h0;
			drv_next = 1'b0;
		end else if (stop_det) begin
			state_next = ST_IDLE;
			drv_next = 1'b0;
		end else if (scl_rise) begin
			cnt_next = (cnt_reg == BIT_COUNT) ? ACK_COUNT : cnt_reg + 4'h1;
			// Host refuses further bytes
			if (cnt_reg == BIT_COUNT && in_read && sda_s2_reg) begin
				state_next = ST_WAIT;
			end
		end else if (scl_fall) begin
			if (cnt_reg == BIT_COUNT) begin
				unique case (state_reg)
					ST_ADDR: begin
						drv_next = addr_hit;
						hi_next = 1'b1;
						state_next = !addr_hit ? ST_WAIT : (shin_reg[0] ? ST_RDATA : ST_PTR);
					end
					ST_PTR: begin
						drv_next = 1'b1;
						ptr_next = shin_reg;
						state_next = ST_WDATA;
					end
					ST_WDATA: begin
						drv_next = 1'b1;
						wr_pulse = 1'b1;
					end
					ST_IDLE, ST_RDATA, ST_WAIT: begin
						drv_next = 1'b0;
					end
					default: begin
						drv_next = 1'b0;
						state_next = ST_WAIT;
					end
				endcase
			end else if (cnt_reg == ACK_COUNT) begin
				cnt_next = 4'h0;
				drv_next = in_read && !rd_byte_i[7];
				tx_next = rd_byte_i;
				rd_pulse = in_read;
				if (in_read) begin
					hi_next = 1'b0;
				end
			end else if (in_read) begin
				drv_next = !tx_reg[6];
				tx_next = {tx_reg[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (scl_rise && cnt_reg < BIT_COUNT) begin
			shin_reg <= {shin_reg[6:0], sda_s2_reg};
		end
		tx_reg <= tx_next;
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 4'h0;
			drv_reg <= 1'b0;
			ptr_reg <= 8'h00;
			hi_reg <= 1'b1;
			busy_o <= 1'b0;
			sda_oe_n_o <= 1'b1;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			drv_reg <= drv_next;
			ptr_reg <= ptr_next;
			hi_reg <= hi_next;
			busy_o <= state_next != ST_IDLE;
			sda_oe_n_o <= !drv_next;
		end
	end

	assign req_o = '{wr: wr_pulse, rd: rd_pulse, hi: hi_reg, ptr: ptr_reg, wdata: shin_reg};
endmodule : serial_link_slave

/* File: src/monitor_result_and_alarm_logic.sv */
`timescale 1ns/100ps
// How it works
// - Eight 16-bit result words sit at consecutive addresses, one per channel.
// - A result read is taken any time and returns the latest conversion stored before the transaction began.
// - A finished conversion waits until the current bus transaction has ended.
// - The last result word holds local temperature, nine bits, two-byte readable.
// - Temperature code counts half degrees, two's complement.
// - Separate writable temperature high and hysteresis thresholds exist.
// - Thresholds are signed whole degrees, doubled before comparing with results.
// - Flag above high limit, at or below low limit, or above temperature high.
// - Interrupt pin pulls low only when clear bit low, enable high, violation flagged.
// - Reading status returns it, then clears it and releases the pin.
// - Clear bit set releases the pin and halts monitoring while it stays set.
// - Temperature alarm stays until status is read or clear bit is set.
// - Alarm recurs each temperature conversion until reading at or below hysteresis and read.
// - Data, clock and interrupt pins only ever pull low.
// - Two three-level strap pins choose one of nine bus addresses.
// - A mask bit keeps its channel off the pin but status still records.
// - After reset start is low and clear bit is high.
// - Lowering the clear bit leaves status untouched.
module monitor_result_and_alarm_logic
	import monitor_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_n_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	output logic int_o,
	output logic int_oe_n_o,
	input wire logic [1:0] addr_sel_pin_lo_i,
	input wire logic [1:0] addr_sel_pin_hi_i,
	input wire conv_s conv_i,
	input wire logic conv_valid_i,
	output logic monitor_run_o
);
	// ==========================================
	// Address straps
	// ==========================================
	logic [1:0] lo_s1_reg, lo_s2_reg, hi_s1_reg, hi_s2_reg;
	logic [6:0] own_addr_reg;

	wire [6:0] lvl_lo = 7'(lo_s2_reg[0]) + 7'(lo_s2_reg[1]);
	wire [6:0] lvl_hi = 7'(hi_s2_reg[0]) + 7'(hi_s2_reg[1]);
	wire [6:0] own_addr_next = 7'(BUS_ADDR_BASE + lvl_hi * STRAP_STEP + lvl_lo);

	always_ff @(posedge core_clk_i) begin
		lo_s1_reg <= addr_sel_pin_lo_i;
		lo_s2_reg <= lo_s1_reg;
		hi_s1_reg <= addr_sel_pin_hi_i;
		hi_s2_reg <= hi_s1_reg;
		own_addr_reg <= own_addr_next;
	end

	// ==========================================
	// Serial link and result store
	// ==========================================
	bus_req_s req;
	logic busy;
	logic [7:0] rd_byte;
	logic [15:0] mem_q;
	logic [15:0] mem_wdata;
	logic commit;
	conv_s pend_reg;

	serial_link_slave u_link (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.own_addr_i(own_addr_reg),
		.rd_byte_i(rd_byte),
		.sda_oe_n_o(sda_oe_n_o),
		.busy_o(busy),
		.req_o(req)
	);

	result_mem u_mem (
		.core_clk_i(core_clk_i),
		.we_i(commit),
		.waddr_i(pend_reg.chan),
		.wdata_i(mem_wdata),
		.raddr_i(req.ptr[2:0]),
		.rdata_o(mem_q)
	);

	// ==========================================
	// Register decode
	// ==========================================
	logic [7:0] cfg_reg, status_reg, mask_reg;
	logic [7:0] lim_reg [LIMIT_COUNT];
	logic pend_valid_reg, temp_latch_reg, hyst_ok_reg;
	logic zero_reg, release_reg;

	wire wr_cfg = req.wr && req.ptr == CFG_ADDR;
	wire wr_mask = req.wr && req.ptr == MASK_ADDR;
	wire in_lim = req.ptr >= LIMIT_BASE && req.ptr <= TEMP_HYST_ADDR;
	wire [3:0] lim_idx = 4'(req.ptr - LIMIT_BASE);
	wire wr_lim = req.wr && in_lim;
	wire rd_status = req.rd && req.ptr == STATUS_ADDR;
	wire in_res = req.ptr[7:3] == RESULT_BASE[7:3];
	wire init = wr_cfg && req.wdata[CFG_INIT_BIT];
	wire int_clear = cfg_reg[CFG_INT_CLEAR_BIT];
	wire [7:0] res_byte = req.hi ? mem_q[15:8] : mem_q[7:0];

	assign rd_byte = (req.ptr == CFG_ADDR) ? cfg_reg :
		(req.ptr == STATUS_ADDR) ? status_reg :
		(req.ptr == MASK_ADDR) ? mask_reg :
		in_res ? res_byte :
		in_lim ? lim_reg[lim_idx] : 8'h00;

	// ==========================================
	// Limit comparison
	// ==========================================
	// hold update during transfer
	assign commit = pend_valid_reg && !busy;
	wire is_temp = pend_reg.chan == TEMP_CHAN;
	wire signed [8:0] temp_val = pend_reg.data[8:0];
	wire signed [8:0] hot_val = {lim_reg[TEMP_HIGH_IDX], 1'b0};
	wire signed [8:0] hyst_val = {lim_reg[TEMP_HYST_IDX], 1'b0};
	wire t_over = temp_val > hot_val;
	wire t_below = temp_val <= hyst_val;
	wire [7:0] v_high = lim_reg[{pend_reg.chan, 1'b0}];
	wire [7:0] v_low = lim_reg[{pend_reg.chan, 1'b1}];
	wire v_over = pend_reg.data > {v_high, 4'h0};
	wire v_under = pend_reg.data <= {v_low, 4'h0};
	wire viol = is_temp ? (t_over || temp_latch_reg) : (v_over || v_under);
	wire [7:0] set_vec = (commit && viol && !int_clear) ? 8'(8'h01 << pend_reg.chan) : 8'h00;
	assign mem_wdata = is_temp ? {pend_reg.data[8:0], 7'h00} : {pend_reg.data, 4'h0};

	// ==========================================
	// Next-state values
	// ==========================================
	// only reads and init clear status
	wire [7:0] status_next = (status_reg & ~{8{rd_status || init}}) | set_vec;
	wire [7:0] cfg_next = init ? CFG_RESET : (wr_cfg ? {1'b0, req.wdata[6:0]} : cfg_reg);
	wire [7:0] mask_next = init ? MASK_RESET : (wr_mask ? req.wdata : mask_reg);
	wire latch_next = (commit && is_temp && t_over) || (temp_latch_reg && !(rd_status && hyst_ok_reg));
	wire hyst_next = (commit && is_temp) ? t_below : hyst_ok_reg;
	wire pend_next = conv_valid_i || (pend_valid_reg && busy);
	wire int_drive = !int_clear && cfg_reg[CFG_INT_EN_BIT] && |(status_reg & ~mask_reg);
	wire run_next = cfg_reg[CFG_START_BIT] && !int_clear;

	// ==========================================
	// State registers
	// ==========================================
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			cfg_reg <= CFG_RESET;
			status_reg <= STATUS_RESET;
			mask_reg <= MASK_RESET;
			pend_valid_reg <= 1'b0;
			temp_latch_reg <= 1'b0;
			hyst_ok_reg <= 1'b0;
			int_oe_n_o <= 1'b1;
			monitor_run_o <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			status_reg <= status_next;
			mask_reg <= mask_next;
			pend_valid_reg <= pend_next;
			temp_latch_reg <= latch_next;
			hyst_ok_reg <= hyst_next;
			int_oe_n_o <= !int_drive;
			monitor_run_o <= run_next;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (conv_valid_i) begin
			pend_reg <= conv_i;
		end
	end

	for (genvar i = 0; i < LIMIT_COUNT; i++) begin : g_lim
		always_ff @(posedge core_clk_i) begin
			if (srst_i) begin
				lim_reg[i] <= LIMIT_RESET;
			end else if (wr_lim && lim_idx == 4'(i)) begin
				lim_reg[i] <= req.wdata;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			zero_reg <= 1'b0;
			release_reg <= 1'b1;
		end else begin
			zero_reg <= 1'b0;
			release_reg <= 1'b1;
		end
	end

	assign scl_o = zero_reg;
	assign sda_o = zero_reg;
	assign int_o = zero_reg;
	assign scl_oe_n_o = release_reg;

	// ==========================================
	// Checks
	// ==========================================
	// update waits for stop
	sequence s_held_back;
		pend_valid_reg && busy;
	endsequence
	property p_hold_back;
		@(posedge core_clk_i) disable iff (srst_i)
		s_held_back |-> !commit ##1 pend_valid_reg;
	endproperty
	a_hold_back: assert property (p_hold_back) else $error("result update not held back");

	property p_int_cause;
		@(posedge core_clk_i) disable iff (srst_i)
		!int_oe_n_o |-> $past(!int_clear && cfg_reg[CFG_INT_EN_BIT] && |(status_reg & ~mask_reg));
	endproperty
	a_int_cause: assert property (p_int_cause) else $error("interrupt driven without cause");

	property p_read_clears;
		@(posedge core_clk_i) disable iff (srst_i)
		rd_status && set_vec == 8'h00 |=> status_reg == 8'h00 ##1 int_oe_n_o;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("status read did not clear");

	property p_clear_bit;
		@(posedge core_clk_i) disable iff (srst_i)
		int_clear |=> int_oe_n_o && !monitor_run_o;
	endproperty
	a_clear_bit: assert property (p_clear_bit) else $error("clear bit did not release");

	property p_reset_values;
		@(posedge core_clk_i) disable iff (srst_i)
		$fell(srst_i) |-> int_clear && !cfg_reg[CFG_START_BIT] && int_oe_n_o;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("wrong values after reset");

	property p_status_kept;
		@(posedge core_clk_i) disable iff (srst_i)
		wr_cfg && !init && !rd_status && set_vec == 8'h00 |=> status_reg == $past(status_reg);
	endproperty
	a_status_kept: assert property (p_status_kept) else $error("status changed by config write");

	property p_volt_flag;
		@(posedge core_clk_i) disable iff (srst_i)
		commit && !is_temp && (v_over || v_under) && !int_clear |=> status_reg[$past(pend_reg.chan)];
	endproperty
	a_volt_flag: assert property (p_volt_flag) else $error("voltage violation not flagged");

	property p_temp_again;
		@(posedge core_clk_i) disable iff (srst_i)
		commit && is_temp && temp_latch_reg && !int_clear |=> status_reg[TEMP_CHAN];
	endproperty
	a_temp_again: assert property (p_temp_again) else $error("temperature alarm not repeated");

	property p_masked;
		@(posedge core_clk_i) disable iff (srst_i)
		(status_reg & ~mask_reg) == 8'h00 |=> int_oe_n_o;
	endproperty
	a_masked: assert property (p_masked) else $error("masked event drove interrupt");

	property p_low_only;
		@(posedge core_clk_i) disable iff (srst_i)
		!sda_o && !scl_o && !int_o;
	endproperty
	a_low_only: assert property (p_low_only) else $error("pin driven high");
endmodule : monitor_result_and_alarm_logic

/* File: tb/serial_host_model.sv */
`timescale 1ns/100ps
module serial_host_model (
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	// ==========================================
	// Bit timing, 320 ns link clock
	// ==========================================
	localparam time HALF = 160ns;

	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	// Waits a full half period so a slave bit has been released first
	task automatic start_cond();
		sda_o = 1'b1;
		#(HALF);
		scl_o = 1'b1;
		#(HALF);
		sda_o = 1'b0;
		#(HALF);
		scl_o = 1'b0;
	endtask : start_cond

	task automatic stop_cond();
		#(HALF / 2);
		sda_o = 1'b0;
		#(HALF / 2);
		scl_o = 1'b1;
		#(HALF);
		sda_o = 1'b1;
		#(HALF);
	endtask : stop_cond

	// Data changes only while the clock is low
	task automatic clock_bit(input logic b, output logic s);
		#(HALF / 2);
		sda_o = b;
		#(HALF / 2);
		scl_o = 1'b1;
		#(HALF * 3 / 4);
		s = sda_i;
		#(HALF / 4);
		scl_o = 1'b0;
	endtask : clock_bit

	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(d[i], s);
		end
		clock_bit(1'b1, s);
		ack = ~s;
	endtask : send_byte

	task automatic recv_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(1'b1, s);
			d[i] = s;
		end
		clock_bit(last, s);
	endtask : recv_byte
endmodule : serial_host_model

/* File: tb/monitor_result_and_alarm_logic_bench.sv */
`timescale 1ns/100ps
module monitor_result_and_alarm_logic_bench;
	import monitor_pkg::*;
	// ==========================================
	// Signals and wiring
	// ==========================================
	localparam logic [6:0] DEV_ADDR = 7'h17;
	localparam int LIMIT = 40000;
	logic core_clk_i;
	logic srst_i;
	logic scl_m;
	logic sda_m;
	logic dut_scl_o;
	logic dut_scl_oe_n;
	logic dut_sda_o;
	logic dut_sda_oe_n;
	logic int_o;
	logic int_oe_n;
	logic [1:0] strap_lo;
	logic [1:0] strap_hi;
	conv_s conv;
	logic conv_valid;
	logic run;
	logic ack;
	logic [15:0] rd;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	wire scl_bus = scl_m & (dut_scl_oe_n | dut_scl_o);
	wire sda_bus = sda_m & (dut_sda_oe_n | dut_sda_o);
	wire int_pin = int_oe_n | int_o;

	monitor_result_and_alarm_logic dut (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.scl_i(scl_bus),
		.scl_o(dut_scl_o),
		.scl_oe_n_o(dut_scl_oe_n),
		.sda_i(sda_bus),
		.sda_o(dut_sda_o),
		.sda_oe_n_o(dut_sda_oe_n),
		.int_o(int_o),
		.int_oe_n_o(int_oe_n),
		.addr_sel_pin_lo_i(strap_lo),
		.addr_sel_pin_hi_i(strap_hi),
		.conv_i(conv),
		.conv_valid_i(conv_valid),
		.monitor_run_o(run)
	);

	serial_host_model host (
		.sda_i(sda_bus),
		.scl_o(scl_m),
		.sda_o(sda_m)
	);

	// ==========================================
	// Access tasks
	// ==========================================
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic pin(input logic seen, input logic exp);
		check({15'h0, seen}, {15'h0, exp});
	endtask : pin

	task automatic send_conv(input logic [2:0] ch, input logic [11:0] d);
		@(negedge core_clk_i);
		conv = conv_s'{chan: ch, data: d};
		conv_valid = 1'b1;
		@(negedge core_clk_i);
		conv_valid = 1'b0;
		repeat (4) @(negedge core_clk_i);
	endtask : send_conv

	task automatic reg_write(input logic [7:0] ptr, input logic [7:0] data);
		host.start_cond();
		host.send_byte({DEV_ADDR, 1'b0}, ack);
		host.send_byte(ptr, ack);
		host.send_byte(data, ack);
		host.stop_cond();
		pin(ack, 1'b1);
	endtask : reg_write

	// Optional conversion lands while the transaction is open
	task automatic reg_read(input logic [7:0] ptr, input bit wide, input bit inj, output logic [15:0] val);
		host.start_cond();
		host.send_byte({DEV_ADDR, 1'b0}, ack);
		host.send_byte(ptr, ack);
		if (inj) send_conv(3'h1, 12'h456);
		host.start_cond();
		host.send_byte({DEV_ADDR, 1'b1}, ack);
		host.recv_byte(!wide, val[15:8]);
		val[7:0] = 8'h00;
		if (wide) host.recv_byte(1'b1, val[7:0]);
		host.stop_cond();
	endtask : reg_read

	task automatic expect8(input logic [7:0] ptr, input logic [7:0] exp);
		logic [15:0] v;
		reg_read(ptr, 1'b0, 1'b0, v);
		check(v, {exp, 8'h00});
	endtask : expect8

	task automatic expect16(input logic [7:0] ptr, input logic [15:0] exp);
		logic [15:0] v;
		reg_read(ptr, 1'b1, 1'b0, v);
		check(v, exp);
	endtask : expect16

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_sim

	// ==========================================
	// Clock, timeout and test sequence
	// ==========================================
	initial begin
		core_clk_i = 1'b0;
		forever #20 core_clk_i = ~core_clk_i;
	end

	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == LIMIT) begin
			errors++;
			$display("ERROR %0t: timeout", $time);
			end_sim();
		end
	end

	initial begin
		srst_i = 1'b1;
		conv = '0;
		conv_valid = 1'b0;
		strap_lo = 2'b01;
		strap_hi = 2'b11;
		repeat (2) @(negedge core_clk_i);
		srst_i = 1'b0;
		repeat (6) @(negedge core_clk_i);
		expect8(CFG_ADDR, CFG_RESET);
		expect8(STATUS_ADDR, 8'h00);
		pin(run, 1'b0);
		host.start_cond();
		host.send_byte({7'h10, 1'b0}, ack);
		host.stop_cond();
		pin(ack, 1'b0);
		expect8(8'h05, 8'h00);
		$display("Test reset and addressing done");
		reg_write(8'h2A, 8'h80);
		reg_write(8'h2B, 8'h10);
		reg_write(8'h2C, 8'hFF);
		reg_write(TEMP_HIGH_ADDR, 8'h19);
		reg_write(TEMP_HYST_ADDR, 8'h14);
		expect8(TEMP_HIGH_ADDR, 8'h19);
		expect8(TEMP_HYST_ADDR, 8'h14);
		reg_write(CFG_ADDR, 8'h01);
		send_conv(3'h0, 12'h123);
		send_conv(3'h1, 12'h111);
		expect16(RESULT_BASE, 16'h1230);
		send_conv(3'h0, 12'h801);
		pin(int_pin, 1'b1);
		reg_write(CFG_ADDR, 8'h03);
		pin(run, 1'b1);
		pin(int_pin, 1'b0);
		expect8(STATUS_ADDR, 8'h01);
		pin(int_pin, 1'b1);
		expect8(STATUS_ADDR, 8'h00);
		$display("Test voltage limits done");
		reg_write(MASK_ADDR, 8'h01);
		send_conv(3'h0, 12'h100);
		pin(int_pin, 1'b1);
		expect8(STATUS_ADDR, 8'h01);
		reg_write(MASK_ADDR, 8'h00);
		$display("Test mask done");
		send_conv(TEMP_CHAN, 12'h033);
		pin(int_pin, 1'b0);
		expect16(TEMP_RESULT_ADDR, 16'h1980);
		repeat (40) @(negedge core_clk_i);
		pin(int_pin, 1'b0);
		expect8(STATUS_ADDR, 8'h80);
		pin(int_pin, 1'b1);
		send_conv(TEMP_CHAN, 12'h02A);
		expect8(STATUS_ADDR, 8'h80);
		send_conv(TEMP_CHAN, 12'h028);
		expect8(STATUS_ADDR, 8'h80);
		send_conv(TEMP_CHAN, 12'h1CE);
		expect8(STATUS_ADDR, 8'h00);
		expect16(TEMP_RESULT_ADDR, 16'hE700);
		$display("Test temperature done");
		send_conv(3'h0, 12'h801);
		reg_write(CFG_ADDR, 8'h0B);
		pin(int_pin, 1'b1);
		pin(run, 1'b0);
		reg_write(CFG_ADDR, 8'h03);
		pin(int_pin, 1'b0);
		expect8(STATUS_ADDR, 8'h01);
		$display("Test clear bit done");
		send_conv(3'h0, 12'h801);
		reg_write(MASK_ADDR, 8'h55);
		pin(int_pin, 1'b1);
		reg_write(CFG_ADDR, 8'h83);
		expect8(CFG_ADDR, CFG_RESET);
		expect8(MASK_ADDR, MASK_RESET);
		expect8(STATUS_ADDR, STATUS_RESET);
		expect8(8'h2A, 8'h80);
		pin(run, 1'b0);
		pin(int_pin, 1'b1);
		$display("Test init bit done");
		reg_read(RESULT_BASE + 8'h01, 1'b1, 1'b1, rd);
		check(rd, 16'h1110);
		expect16(RESULT_BASE + 8'h01, 16'h4560);
		pin(dut_scl_oe_n, 1'b1);
		pin(dut_scl_o, 1'b0);
		pin(dut_sda_o, 1'b0);
		pin(int_o, 1'b0);
		$display("Test bus hold-off and pins done");
		end_sim();
	end
endmodule : monitor_result_and_alarm_logic_bench
